// file: verification/dsadc_far_model.sv
`timescale 1ns/1ps
module dsadc_far_model (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic eoc_in,
   input wire logic ack_en_in,
   input wire logic [3:0] ack_dly_in,
   input wire logic bit_mode_in,
   output logic mod_bit_out,
   output logic dma_ack_out
);
   logic [3:0] wait_cnt;
   logic [1:0] guard;
   // ----------------------------------------------------------------
   // modulator stand-in
   // ----------------------------------------------------------------
   // all zeros, or a toggling half-scale stream
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         mod_bit_out <= 1'b0;
      end else begin
         mod_bit_out <= bit_mode_in & ~mod_bit_out;
      end
   end
   // ----------------------------------------------------------------
   // dma reader
   // ----------------------------------------------------------------
   // guard gap so a flag still falling is not acked twice
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         wait_cnt <= 4'h0;
         guard <= 2'h0;
         dma_ack_out <= 1'b0;
      end else begin
         dma_ack_out <= 1'b0;
         if (guard != 2'h0) begin
            guard <= guard - 2'h1;
         end else if (ack_en_in && eoc_in) begin
            if (wait_cnt == ack_dly_in) begin
               dma_ack_out <= 1'b1;
               wait_cnt <= 4'h0;
               guard <= 2'h3;
            end else begin
               wait_cnt <= wait_cnt + 4'h1;
            end
         end else begin
            wait_cnt <= 4'h0;
         end
      end
   end
endmodule

// file: verification/tb.sv
`timescale 1ns/1ps
module tb;
   import dsadc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = HSIZE_WORD;
   logic [31:0] hwdata = 32'h0;
   logic soc = 1'b0;
   logic ack_en = 1'b0;
   logic [3:0] ack_dly = 4'h2;
   logic bit_mode = 1'b0;
   logic [31:0] hrdata;
   logic hready, hresp, mod_bit, dma_ack, eoc, irq, mrst, busy;
   logic [RES_W-1:0] result;
   logic [SEL_W-1:0] msel;
   int num_errors = 0;
   int n_checks = 0;
   always #12.5 clk = ~clk;
   dsadc_seq i_dut (
      .REF_CLK_IN(clk), .RST_IN(rst), .HSEL_IN(hsel),
      .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
      .HSIZE_IN(hsize), .HWDATA_IN(hwdata), .HREADY_IN(hready),
      .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
      .MOD_BIT_IN(mod_bit), .SOC_IN(soc), .DMA_ACK_IN(dma_ack),
      .RESULT_OUT(result), .EOC_OUT(eoc), .IRQ_OUT(irq),
      .MOD_RESET_OUT(mrst), .MUX_SEL_OUT(msel), .BUSY_OUT(busy)
   );
   dsadc_far_model i_far (
      .clk_in(clk), .rst_in(rst), .eoc_in(eoc), .ack_en_in(ack_en),
      .ack_dly_in(ack_dly), .bit_mode_in(bit_mode),
      .mod_bit_out(mod_bit), .dma_ack_out(dma_ack)
   );
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic report_and_stop();
      if (num_errors == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic in_win(input int n, input int lo, input int hi);
      check(32'(n >= lo && n <= hi), 32'h1);
   endtask
   // sample at the negedge: same value as at the next rising edge
   task automatic wait_rdy(output logic [31:0] d);
      logic r;
      r = 1'b0;
      while (r !== 1'b1) begin
         @(negedge clk);
         r = hready;
         d = hrdata;
         @(posedge clk);
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic w,
                      input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      wait_rdy(rd);
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy(rd);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(a, 1'b1, d, x);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      bus(a, 1'b0, 32'h0, d);
   endtask
   function automatic logic sig(input int i);
      case (i)
         0: return eoc;
         1: return mrst;
         default: return busy;
      endcase
   endfunction
   task automatic wait_for(input int i, input logic v, input int lim,
                           output int n);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (sig(i) !== v && n < lim);
      check(sig(i), v);
      @(posedge clk);
   endtask
   task automatic soc_pulse();
      soc <= 1'b1;
      repeat (4) @(posedge clk);
      soc <= 1'b0;
      @(posedge clk);
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      logic [31:0] d;
      check(hready, 1'b1);
      check({eoc, busy, irq, mrst, hresp}, 5'h0);
      rd(REG_IRQ_EN, d);
      check(d, 32'(IRQ_EN_RST));
      rd(8'h40, d);
      check(d, 32'h0);
   endtask
   task automatic t_single12();
      logic [31:0] d;
      int n;
      wr(REG_CTRL, 32'h10);
      wait_for(1, 1'b1, 8, n);
      wait_for(1, 1'b0, 100, n);
      check(n, int'(MRST_CYC));
      wait_for(0, 1'b1, 1000, n);
      in_win(n, 4 * int'(DEC12_CYC) - 3, 4 * int'(DEC12_CYC) + 3);
      check(result, 12'h000);
      repeat (20) @(posedge clk);
      check({eoc, busy}, 2'h3);
      rd(REG_RESULT, d);
      check(d, 32'h0);
      repeat (2) @(posedge clk);
      check({eoc, busy}, 2'h0);
      repeat (300) @(posedge clk);
      check({eoc, busy, mrst}, 3'h0);
   endtask
   task automatic t_soc8();
      logic [31:0] d;
      int n;
      wr(REG_CTRL, 32'h04);
      repeat (50) @(posedge clk);
      check(busy, 1'b0);
      soc_pulse();
      repeat (100) @(posedge clk);
      soc_pulse();
      wait_for(0, 1'b1, 1000, n);
      n = n + 110;
      in_win(n, int'(MRST_CYC) + 4 * int'(DEC8_CYC),
             int'(MRST_CYC) + 4 * int'(DEC8_CYC) + 8);
      rd(REG_IRQ_STAT, d);
      check(d, 32'h3);
      check(irq, 1'b0);
      ack_en <= 1'b1;
      wait_for(0, 1'b0, 20, n);
      check(n < 20, 1'b1);
      repeat (600) @(posedge clk);
      check({eoc, busy}, 2'h0);
      wr(REG_IRQ_EN, 32'h1);
      repeat (3) @(posedge clk);
      check(irq, 1'b1);
      wr(REG_IRQ_CLR, 32'h1);
      repeat (3) @(posedge clk);
      check(irq, 1'b0);
      rd(REG_IRQ_STAT, d);
      check(d, 32'h2);
      wr(REG_IRQ_CLR, 32'h2);
      wr(REG_IRQ_EN, 32'h0);
   endtask
   task automatic t_modes();
      dsadc_mode_type ml [3] = '{MODE_CONT, MODE_MULTI, MODE_TURBO};
      int n, n2, gap, per;
      bit_mode <= 1'b1;
      foreach (ml[k]) begin
         gap = (ml[k] == MODE_TURBO) ? int'(TURBO_RST_CYC)
                                     : int'(MRST_CYC);
         per = (ml[k] == MODE_CONT) ? int'(DEC8_CYC)
                                    : gap + 4 * int'(DEC8_CYC);
         wr(REG_CTRL, 32'h14 | 32'(ml[k]));
         wait_for(0, 1'b1, 1000, n);
         in_win(n, gap + 4 * int'(DEC8_CYC) - 4,
                gap + 4 * int'(DEC8_CYC) + 4);
         for (int j = 0; j < 2; j++) begin
            wait_for(0, 1'b0, 20, n);
            wait_for(0, 1'b1, 1000, n2);
            in_win(n + n2, per - 4, per + 4);
         end
         check(busy, 1'b1);
         wr(REG_CTRL, 32'h20);
         repeat (10) @(posedge clk);
         check(busy, 1'b0);
      end
   endtask
   task automatic t_insel();
      int n;
      wr(REG_CTRL, 32'h15);
      wait_for(0, 1'b1, 1000, n);
      repeat (200) @(posedge clk);
      wr(REG_INSEL, 32'h5);
      @(negedge clk);
      check(msel, 4'h5);
      wait_for(0, 1'b1, 1000, n);
      in_win(n, 4 * int'(DEC8_CYC) - 4,
             int'(MRST_CYC) + 4 * int'(DEC8_CYC) + 8);
      wr(REG_CTRL, 32'h20);
      repeat (10) @(posedge clk);
   endtask
   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_single12();
      t_soc8();
      t_modes();
      t_insel();
      report_and_stop();
   end
   // run needs about 7000 cycles
   initial begin
      repeat (40000) @(posedge clk);
      num_errors++;
      report_and_stop();
   end
endmodule

// file: verilog/dsadc_pkg.sv
package dsadc_pkg;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 40_000_000;
   localparam int RATE12_SPS = 192_000;
   localparam int RATE8_SPS = 384_000;
   localparam int CNT_W = 8;
   // a longest rate gives a least period: round the ratio up
   localparam logic [CNT_W-1:0] DEC12_CYC =
      CNT_W'((CLK_HZ + RATE12_SPS - 1) / RATE12_SPS);
   localparam logic [CNT_W-1:0] DEC8_CYC =
      CNT_W'((CLK_HZ + RATE8_SPS - 1) / RATE8_SPS);
   localparam int MRST_NS = 1000;
   localparam logic [CNT_W-1:0] MRST_CYC =
      CNT_W'((MRST_NS * (CLK_HZ / 1_000_000) + 999) / 1000);
   localparam logic [CNT_W-1:0] TURBO_RST_CYC = 8'h01;
   // ----------------------------------------------------------------
   // datapath
   // ----------------------------------------------------------------
   localparam int ACC_W = 34;
   localparam int RES_W = 12;
   localparam int RES8_W = 8;
   localparam int RES12_MSB = 30;
   localparam int RES8_MSB = 26;
   localparam int PRIME_W = 2;
   localparam logic [PRIME_W-1:0] PRIME_LAST = 2'h3;
   localparam int SEL_W = 4;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam int AW = 8;
   localparam logic [AW-1:0] REG_CTRL = 8'h00;
   localparam logic [AW-1:0] REG_INSEL = 8'h04;
   localparam logic [AW-1:0] REG_STATUS = 8'h08;
   localparam logic [AW-1:0] REG_RESULT = 8'h0C;
   localparam logic [AW-1:0] REG_IRQ_STAT = 8'h10;
   localparam logic [AW-1:0] REG_IRQ_EN = 8'h14;
   localparam logic [AW-1:0] REG_IRQ_CLR = 8'h18;
   localparam int CTRL_MODE_LSB = 0;
   localparam int MODE_W = 2;
   localparam int CTRL_RES8_BIT = 2;
   localparam int CTRL_START_BIT = 4;
   localparam int CTRL_STOP_BIT = 5;
   localparam int IRQ_W = 2;
   localparam int IRQ_CONV_BIT = 0;
   localparam int IRQ_TRIG_BIT = 1;
   localparam logic [IRQ_W-1:0] IRQ_EN_RST = 2'h0;
   localparam logic [SEL_W-1:0] SEL_RST = 4'h0;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam int HTRANS_ACT_BIT = 1;

   typedef enum logic [1:0] {
      MODE_SINGLE = 2'b00,
      MODE_MULTI = 2'b01,
      MODE_CONT = 2'b10,
      MODE_TURBO = 2'b11
   } dsadc_mode_type;

   typedef enum logic [1:0] {
      ST_STANDBY = 2'b00,
      ST_MODRST = 2'b01,
      ST_PRIME = 2'b10,
      ST_HOLD = 2'b11
   } dsadc_state_type;
endpackage

// file: verilog/dsadc_seq.sv
`timescale 1ns/1ps
// Notes on behaviour
// RQ1 - 12-bit to 192 ksps, 8-bit to 384 ksps
// RQ2 - decimator alone sets resolution and rate
// RQ3 - fourth-order sinc response
// RQ4 - output depends on last four samples
// RQ5 - after input switch, valid from fourth sample
// RQ6 - single, multi, continuous, turbo multi modes
// RQ7 - start by control bit or trigger
// RQ8 - completion flag and output held until read; RESULT_OUT is held only in single mode, later results overwrite it
// RQ9 - single: four conversions, fourth is result
// RQ10 - single: back to standby after transfer
// RQ11 - continuous: three-period priming, then free running
// RQ12 - host avoids input switching in continuous
// RQ13 - multi: reset and re-prime between samples
// RQ14 - multi: next sample starts automatically
// RQ15 - trigger optional, continuous runs without it
// RQ16 - completion output rises every conversion
// RQ17 - trigger synchronised, edge counted, busy ignores
// RQ18 - turbo follows multi, shorter reset gap
module dsadc_seq (
   input wire logic REF_CLK_IN,
   input wire logic RST_IN,
   input wire logic HSEL_IN,
   input wire logic [31:0] HADDR_IN,
   input wire logic [1:0] HTRANS_IN,
   input wire logic HWRITE_IN,
   input wire logic [2:0] HSIZE_IN,
   input wire logic [31:0] HWDATA_IN,
   input wire logic HREADY_IN,
   output logic [31:0] HRDATA_OUT,
   output logic HREADYOUT_OUT,
   output logic HRESP_OUT,
   input wire logic MOD_BIT_IN,
   input wire logic SOC_IN,
   input wire logic DMA_ACK_IN,
   output logic [dsadc_pkg::RES_W-1:0] RESULT_OUT,
   output logic EOC_OUT,
   output logic IRQ_OUT,
   output logic MOD_RESET_OUT,
   output logic [dsadc_pkg::SEL_W-1:0] MUX_SEL_OUT,
   output logic BUSY_OUT
);
   import dsadc_pkg::*;

   function automatic logic hits(input logic [AW-1:0] a,
                                 input logic [AW-1:0] off);
      hits = (a == off);
   endfunction

   function automatic logic [ACC_W-1:0] acc_add(
      input logic [ACC_W-1:0] a, input logic [ACC_W-1:0] b);
      acc_add = a + b;
   endfunction

   function automatic logic [ACC_W-1:0] acc_sub(
      input logic [ACC_W-1:0] a, input logic [ACC_W-1:0] b);
      acc_sub = a - b;
   endfunction

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   logic soc_s1, soc_s2, soc_s3;
   logic mod_s1, mod_s2;
   logic trig;

   always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         soc_s1 <= 1'b0;
         soc_s2 <= 1'b0;
         soc_s3 <= 1'b0;
         mod_s1 <= 1'b0;
         mod_s2 <= 1'b0;
      end else begin
         soc_s1 <= SOC_IN;
         soc_s2 <= soc_s1;
         soc_s3 <= soc_s2;
         mod_s1 <= MOD_BIT_IN;
         mod_s2 <= mod_s1;
      end
   end

   // a level held high starts only one sequence
   assign trig = soc_s2 & ~soc_s3; // RQ17

   // ----------------------------------------------------------------
   // bus slave
   // ----------------------------------------------------------------
   // reads take one wait state so a write just before is seen
   logic ap_valid;
   logic wr_pend, rd_pend;
   logic [AW-1:0] dp_addr;
   logic [31:0] rd_mux;

   assign ap_valid = HSEL_IN & HTRANS_IN[HTRANS_ACT_BIT] & HREADY_IN;

   always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         dp_addr <= '0;
      end else begin
         wr_pend <= ap_valid & HWRITE_IN & (HSIZE_IN == HSIZE_WORD);
         rd_pend <= ap_valid & ~HWRITE_IN;
         if (ap_valid) begin
            dp_addr <= HADDR_IN[AW-1:0];
         end
      end
   end

   assign HREADYOUT_OUT = ~rd_pend;
   assign HRESP_OUT = 1'b0;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   dsadc_mode_type mode;
   dsadc_state_type state;
   logic res8;
   logic [SEL_W-1:0] sel;
   logic [IRQ_W-1:0] irq_stat, irq_en, irq_ev;
   logic wr_ctrl, wr_insel, sel_change;
   logic start_req, stop_req, res_taken;
   logic eoc, load, tick, irq_line;
   logic [PRIME_W-1:0] prime_cnt;
   logic [RES_W-1:0] result;

   assign wr_ctrl = wr_pend & hits(dp_addr, REG_CTRL);
   assign wr_insel = wr_pend & hits(dp_addr, REG_INSEL);
   assign sel_change = wr_insel & (HWDATA_IN[SEL_W-1:0] != sel);
   // the trigger may be left unconnected: software start suffices
   assign start_req = (wr_ctrl & HWDATA_IN[CTRL_START_BIT]) | trig; // RQ7 RQ15
   assign stop_req = wr_ctrl & HWDATA_IN[CTRL_STOP_BIT];
   assign res_taken = (rd_pend & hits(dp_addr, REG_RESULT)) | DMA_ACK_IN;

   always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         mode <= MODE_SINGLE;
         res8 <= 1'b0;
      end else if (wr_ctrl) begin
         mode <= dsadc_mode_type'(HWDATA_IN[CTRL_MODE_LSB +: MODE_W]); // RQ6
         res8 <= HWDATA_IN[CTRL_RES8_BIT]; // RQ1
      end
   end

   always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         sel <= SEL_RST;
      end else if (wr_insel) begin
         sel <= HWDATA_IN[SEL_W-1:0];
      end
   end

   always_comb begin
      rd_mux = '0;
      if (hits(dp_addr, REG_CTRL)) begin
         rd_mux = {29'h0, res8, mode};
      end else if (hits(dp_addr, REG_INSEL)) begin
         rd_mux = {28'h0, sel};
      end else if (hits(dp_addr, REG_STATUS)) begin
         rd_mux = {25'h0, prime_cnt == PRIME_LAST, state, prime_cnt,
                   eoc, state != ST_STANDBY};
      end else if (hits(dp_addr, REG_RESULT)) begin
         rd_mux = {20'h0, result};
      end else if (hits(dp_addr, REG_IRQ_STAT)) begin
         rd_mux = {30'h0, irq_stat};
      end else if (hits(dp_addr, REG_IRQ_EN)) begin
         rd_mux = {30'h0, irq_en};
      end
   end

   always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         HRDATA_OUT <= '0;
      end else if (rd_pend) begin
         HRDATA_OUT <= rd_mux;
      end
   end

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   logic [CNT_W-1:0] cnt, limit;

   always_comb begin
      if (state == ST_MODRST) begin
         // turbo trades settling time for a shorter restart gap
         limit = (mode == MODE_TURBO) ? TURBO_RST_CYC : MRST_CYC; // RQ18
      end else begin
         limit = res8 ? DEC8_CYC : DEC12_CYC; // RQ1 RQ2
      end
   end

   assign tick = (state == ST_PRIME) && (cnt == limit - 8'h01);
   assign load = tick && (prime_cnt == PRIME_LAST) && !sel_change; // RQ4

   always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         cnt <= '0;
      end else if (state == ST_STANDBY || state == ST_HOLD ||
                   sel_change || cnt == limit - 8'h01) begin // RQ5
         cnt <= '0;
      end else begin
         cnt <= cnt + 8'h01;
      end
   end

   always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         state <= ST_STANDBY;
      end else if (stop_req) begin
         state <= ST_STANDBY;
      end else begin
         unique case (state)
            ST_STANDBY: begin
               if (start_req) begin
                  state <= ST_MODRST; // RQ7
               end
            end
            ST_MODRST: begin
               if (cnt == limit - 8'h01) begin
                  state <= ST_PRIME;
               end
            end
            ST_PRIME: begin
               if (load) begin
                  unique case (mode)
                     MODE_SINGLE: state <= ST_HOLD; // RQ9
                     MODE_CONT: state <= ST_PRIME; // RQ11
                     MODE_MULTI,
                     MODE_TURBO: state <= ST_MODRST; // RQ13 RQ14 RQ18
                  endcase
               end
            end
            ST_HOLD: begin
               if (res_taken) begin
                  state <= ST_STANDBY; // RQ10
               end
            end
         endcase
      end
   end

   // priming count: fourth conversion after reset or switch is valid
   always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         prime_cnt <= '0;
      end else if (state == ST_MODRST || sel_change) begin
         prime_cnt <= '0; // RQ5 RQ13
      end else if (tick && prime_cnt != PRIME_LAST) begin
         prime_cnt <= prime_cnt + 2'h1; // RQ9 RQ11
      end
   end

   assign MOD_RESET_OUT = (state == ST_MODRST); // RQ13
   assign BUSY_OUT = (state != ST_STANDBY);
   assign MUX_SEL_OUT = sel;

   // ----------------------------------------------------------------
   // sinc4 decimator
   // ----------------------------------------------------------------
   logic [ACC_W-1:0] i1, i2, i3, i4, d1, d2, d3, d4;
   logic [ACC_W-1:0] c1, c2, c3, c4;
   logic [RES_W-1:0] res_word;

   // wrap-around arithmetic is exact while width exceeds the gain
   always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         i1 <= '0;
         i2 <= '0;
         i3 <= '0;
         i4 <= '0;
      end else if (state != ST_PRIME || sel_change) begin // RQ5
         i1 <= '0;
         i2 <= '0;
         i3 <= '0;
         i4 <= '0;
      end else begin
         i1 <= acc_add(i1, {{(ACC_W-1){1'b0}}, mod_s2}); // RQ2 RQ3
         i2 <= acc_add(i2, i1); // RQ3
         i3 <= acc_add(i3, i2); // RQ3
         i4 <= acc_add(i4, i3); // RQ3
      end
   end

   assign c1 = acc_sub(i4, d1);
   assign c2 = acc_sub(c1, d2);
   assign c3 = acc_sub(c2, d3);
   assign c4 = acc_sub(c3, d4);

   always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         d1 <= '0;
         d2 <= '0;
         d3 <= '0;
         d4 <= '0;
      end else if (state != ST_PRIME || sel_change) begin // RQ5
         d1 <= '0;
         d2 <= '0;
         d3 <= '0;
         d4 <= '0;
      end else if (tick) begin
         d1 <= i4; // RQ3 RQ4
         d2 <= c1;
         d3 <= c2;
         d4 <= c3;
      end
   end

   assign res_word = res8 ? {4'h0, c4[RES8_MSB -: RES8_W]}
                          : c4[RES12_MSB -: RES_W]; // RQ1 RQ2

   always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         result <= '0;
      end else if (load) begin
         result <= res_word;
      end
   end

   assign RESULT_OUT = result;

   // ----------------------------------------------------------------
   // completion flag and interrupts
   // ----------------------------------------------------------------
   // a new result in the cycle of a read keeps the flag set
   always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         eoc <= 1'b0;
      end else if (load) begin
         eoc <= 1'b1; // RQ8 RQ16
      end else if (res_taken) begin
         eoc <= 1'b0; // RQ8
      end
   end

   assign EOC_OUT = eoc;

   always_comb begin
      irq_ev = '0;
      irq_ev[IRQ_CONV_BIT] = load;
      irq_ev[IRQ_TRIG_BIT] = trig && (state != ST_STANDBY); // RQ17
   end

   always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         irq_stat <= '0;
      end else if (wr_pend && hits(dp_addr, REG_IRQ_CLR)) begin
         irq_stat <= (irq_stat & ~HWDATA_IN[IRQ_W-1:0]) | irq_ev;
      end else begin
         irq_stat <= irq_stat | irq_ev;
      end
   end

   always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         irq_en <= IRQ_EN_RST;
      end else if (wr_pend && hits(dp_addr, REG_IRQ_EN)) begin
         irq_en <= HWDATA_IN[IRQ_W-1:0];
      end
   end

   always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         irq_line <= 1'b0;
      end else begin
         irq_line <= |(irq_stat & irq_en);
      end
   end

   assign IRQ_OUT = irq_line;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   chk_eoc_holds: assert property ( // RQ8
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      eoc && !res_taken |=> eoc)
      else $error("completion flag dropped without a read");

   chk_eoc_read: assert property ( // RQ8
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      res_taken && !load |=> !EOC_OUT)
      else $error("completion flag survived a result read");

   chk_eoc_rise: assert property ( // RQ16
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      load |=> EOC_OUT && RESULT_OUT == $past(res_word))
      else $error("conversion end did not raise flag and result");

   chk_start_run: assert property ( // RQ7
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      state == ST_STANDBY && start_req && !stop_req
      |=> MOD_RESET_OUT && BUSY_OUT)
      else $error("start did not begin a sequence");

   chk_fourth_only: assert property ( // RQ9
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      load |-> $past(prime_cnt) == PRIME_LAST - 2'h1
               || $past(prime_cnt) == PRIME_LAST)
      else $error("result presented before three priming conversions");

   chk_single_hold: assert property ( // RQ10
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      state == ST_HOLD && res_taken |=> state == ST_STANDBY)
      else $error("single mode did not return to standby");

   chk_multi_again: assert property ( // RQ14
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      load && !stop_req && (mode == MODE_MULTI || mode == MODE_TURBO)
      |=> MOD_RESET_OUT ##1 (MOD_RESET_OUT || state == ST_PRIME))
      else $error("multi mode did not restart with a reset");

   chk_cont_stays: assert property ( // RQ11
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      load && !stop_req && mode == MODE_CONT
      |=> state == ST_PRIME && prime_cnt == PRIME_LAST)
      else $error("continuous mode re-primed after a result");

   chk_switch_void: assert property ( // RQ5
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      sel_change |=> prime_cnt == 2'h0 && !$rose(eoc))
      else $error("input switch did not void the pipeline");

   chk_busy_ignore: assert property ( // RQ17
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      trig && state == ST_PRIME && !tick && !stop_req && !sel_change
      |=> state == ST_PRIME && $stable(prime_cnt))
      else $error("trigger disturbed a running sequence");

   chk_turbo_gap: assert property ( // RQ18
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      $rose(MOD_RESET_OUT) && mode == MODE_TURBO && !stop_req
      |=> !MOD_RESET_OUT)
      else $error("turbo reset gap longer than one cycle");

endmodule
